//--- inc/lvbc_pkg.sv
package lvbc_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int LVBC_CLK_KHZ = 10000; // sys_clk rate
	localparam int LVBC_DISCH_US = 50; // output discharge time
	localparam int LVBC_DISCH_CYC = LVBC_DISCH_US * LVBC_CLK_KHZ / 1000;
	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [3:0] LVBC_A_VOLT = 4'h0;
	localparam logic [3:0] LVBC_A_MODE = 4'h1;
	localparam logic [3:0] LVBC_A_CFG = 4'h2;
	localparam logic [3:0] LVBC_A_STAT = 4'h3;
	localparam logic [3:0] LVBC_A_ICLR = 4'h4;
	localparam logic [3:0] LVBC_A_IEN = 4'h5;
	localparam int LVBC_RUN_LSB = 0; // mode register
	localparam int LVBC_STBY_LSB = 2;
	localparam int LVBC_ILIM_LSB = 0; // config register
	localparam int LVBC_PHASE_LSB = 2;
	localparam int LVBC_IRQ_BIT = 0; // status, clear, enable
	localparam logic [1:0] LVBC_MODE_ON_RST = 2'h3;
	localparam logic [1:0] LVBC_MODE_OFF_RST = 2'h0;
	localparam logic [2:0] LVBC_PHASE_RST = 3'h7;
	localparam logic [1:0] LVBC_ILIM_RST = 2'h0;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {LVBC_OFF, LVBC_PWM, LVBC_PFM, LVBC_AUTOSKIP} lvbc_mode_t;
	typedef enum logic [1:0] {LVBC_ST_LOAD, LVBC_ST_RUN, LVBC_ST_DISCH} lvbc_state_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lvbc_bus_t;
	typedef struct packed {
		logic [4:0] voltage_code;
		logic in_sequence;
		logic [1:0] inductor_select;
	} lvbc_otp_t;
	typedef struct packed {
		logic enable;
		logic discharge;
		lvbc_mode_t mode;
		logic [12:0] target_mv;
		logic [12:0] ilim_ma;
		logic [8:0] phase_deg;
		logic [10:0] inductor_nh;
	} lvbc_drive_t;
endpackage

//--- rtl/lvbc_top.sv
// Summary of operation
// [R01] one 5-bit code sets run and standby voltage
// [R02] code maps 1.00 V upward, 27-31 give 4.10
// [R03] code change while on: discharge, then restart
// [R04] voltage code loaded from OTP at power up
// [R05] run mode defaults autoskip if sequenced, else off
// [R06] standby mode defaults autoskip if sequenced, else off
// [R07] mode 00 off, 01 PWM, 10 PFM, 11 autoskip
// [R08] mode change raises irq, pin low if enabled
// [R09] run to standby keeps voltage, only enable changes; the code also switches drive.mode to the standby field
// [R10] current limit code 2.1, 2.6, 3.0, 4.5 A
// [R11] phase code 45 degree steps, 111 is zero
// [R12] phase zero at power up, writable when on
// [R13] OTP inductor 1.0, 0.47, 1.5 uH, 11 reserved
// [R14] run field in run, standby field in standby
// [R15] irq flag sticky until software clears it
//
// Implementation choices: strobed register access and the register offsets.
module lvbc_top
	import lvbc_pkg::*;
#(
	parameter int DISCHARGE_CYCLES = LVBC_DISCH_CYC
)(
	input wire logic sys_clk,
	input wire logic srst,
	input wire lvbc_bus_t reg_bus,
	output logic [7:0] rdata,
	input wire lvbc_otp_t otp,
	input wire logic system_on,
	input wire logic standby_state,
	output lvbc_drive_t drive,
	output logic interrupt_out_n
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (DISCHARGE_CYCLES < 1 || DISCHARGE_CYCLES > 900)
		$error("discharge count out of range");

	localparam int DIS_MAX = DISCHARGE_CYCLES + 2; // window for assertions

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		lvbc_state_t state; // load, run or discharge
		logic [9:0] cnt; // discharge cycles left
		logic [4:0] output_voltage_code; // written code
		logic [4:0] applied_code; // code driven to regulator
		logic [1:0] run_state_mode_field;
		logic [1:0] standby_state_mode_field;
		logic [1:0] current_limit_select;
		logic [2:0] switch_phase_field;
		logic [1:0] inductor_select_otp;
		logic mode_change_irq; // sticky flag
		logic irq_en;
		logic irq_n;
		lvbc_mode_t prev_mode; // last selected mode
		logic [7:0] rdata;
		lvbc_drive_t drive;
	} lvbc_regs_t;

	lvbc_regs_t cur; // registered state
	lvbc_regs_t next_cur; // next value

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	// voltage code to millivolt target
	function automatic logic [12:0] volt_mv(input logic [4:0] c);
		case (c)
			5'h00: volt_mv = 13'd1000;
			5'h01: volt_mv = 13'd1100;
			5'h02: volt_mv = 13'd1200;
			5'h03: volt_mv = 13'd1250;
			5'h04: volt_mv = 13'd1300;
			5'h05: volt_mv = 13'd1350;
			5'h06: volt_mv = 13'd1500;
			5'h07: volt_mv = 13'd1600;
			5'h08: volt_mv = 13'd1800;
			5'h09: volt_mv = 13'd1850;
			5'h0A: volt_mv = 13'd2000;
			5'h0B: volt_mv = 13'd2100;
			5'h0C: volt_mv = 13'd2150;
			5'h0D: volt_mv = 13'd2250;
			5'h0E: volt_mv = 13'd2300;
			5'h0F: volt_mv = 13'd2400;
			5'h10: volt_mv = 13'd2500;
			5'h11: volt_mv = 13'd2800;
			5'h12: volt_mv = 13'd3150;
			5'h13: volt_mv = 13'd3200;
			5'h14: volt_mv = 13'd3250;
			5'h15: volt_mv = 13'd3300;
			5'h16: volt_mv = 13'd3350;
			5'h17: volt_mv = 13'd3400;
			5'h18: volt_mv = 13'd3500;
			5'h19: volt_mv = 13'd3800;
			5'h1A: volt_mv = 13'd4000;
			default: volt_mv = 13'd4100; // 27 to 31 saturate
		endcase
	endfunction

	// current limit select to peak milliamps
	function automatic logic [12:0] ilim_ma(input logic [1:0] c);
		case (c)
			2'h0: ilim_ma = 13'd2100;
			2'h1: ilim_ma = 13'd2600;
			2'h2: ilim_ma = 13'd3000;
			default: ilim_ma = 13'd4500;
		endcase
	endfunction

	// phase code to degrees; all ones wraps to zero
	function automatic logic [8:0] phase_deg(input logic [2:0] c);
		phase_deg = (c == 3'h7) ? 9'd0 : 9'(({6'h0, c} + 9'd1) * 9'd45);
	endfunction

	// inductor code to nanohenry; reserved reads as zero
	function automatic logic [10:0] ind_nh(input logic [1:0] c);
		case (c)
			2'h0: ind_nh = 11'd1000;
			2'h1: ind_nh = 11'd470;
			2'h2: ind_nh = 11'd1500;
			default: ind_nh = 11'd0;
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// one pass: sequencer, register writes, irq, then drive
	always_comb
	begin
		logic vwr; // write to voltage register
		logic [4:0] wcode; // code being written
		lvbc_mode_t sel; // mode field selected by state
		vwr = 1'b0;
		wcode = 5'h00;
		sel = LVBC_OFF;
		next_cur = cur;
		next_cur.rdata = 8'h00; // read data stands one cycle only
		vwr = reg_bus.wr && reg_bus.addr == LVBC_A_VOLT && cur.state != LVBC_ST_LOAD;
		wcode = reg_bus.wdata[4:0];
		case (cur.state)
			LVBC_ST_LOAD:
			begin
				// otp sampled one cycle after reset release
				next_cur.output_voltage_code = otp.voltage_code; // [R04]
				next_cur.applied_code = otp.voltage_code; // [R04]
				next_cur.run_state_mode_field = otp.in_sequence ?
					LVBC_MODE_ON_RST : LVBC_MODE_OFF_RST; // [R05]
				next_cur.standby_state_mode_field = otp.in_sequence ?
					LVBC_MODE_ON_RST : LVBC_MODE_OFF_RST; // [R06]
				next_cur.inductor_select_otp = otp.inductor_select; // [R13]
				next_cur.state = LVBC_ST_RUN;
			end
			LVBC_ST_RUN:
			begin
				if (vwr)
				begin
					next_cur.output_voltage_code = wcode; // [R01]
					// live regulator must discharge before retargeting
					if (system_on && cur.drive.enable && wcode != cur.applied_code)
					begin
						next_cur.state = LVBC_ST_DISCH; // [R03]
						next_cur.cnt = 10'(DISCHARGE_CYCLES - 1);
					end
					else
					begin
						next_cur.applied_code = wcode; // off, disabled or same code: no ramp to undo
					end
				end
			end
			LVBC_ST_DISCH:
			begin
				// a write during discharge is picked up at restart
				if (vwr)
					next_cur.output_voltage_code = wcode;
				if (cur.cnt == 10'h000)
				begin
					next_cur.applied_code = next_cur.output_voltage_code; // [R03]
					next_cur.state = LVBC_ST_RUN;
				end
				else
				begin
					next_cur.cnt = cur.cnt - 10'h001;
				end
			end
			default:
			begin
				next_cur.state = LVBC_ST_LOAD;
			end
		endcase
		// control writes
		if (reg_bus.wr && cur.state != LVBC_ST_LOAD)
		begin
			case (reg_bus.addr)
				LVBC_A_MODE:
				begin
					next_cur.run_state_mode_field = reg_bus.wdata[LVBC_RUN_LSB +: 2];
					next_cur.standby_state_mode_field = reg_bus.wdata[LVBC_STBY_LSB +: 2];
				end
				LVBC_A_CFG:
				begin
					next_cur.current_limit_select = reg_bus.wdata[LVBC_ILIM_LSB +: 2];
					next_cur.switch_phase_field = reg_bus.wdata[LVBC_PHASE_LSB +: 3]; // [R12]
				end
				LVBC_A_IEN:
				begin
					next_cur.irq_en = reg_bus.wdata[LVBC_IRQ_BIT];
				end
				LVBC_A_ICLR:
				begin
					if (reg_bus.wdata[LVBC_IRQ_BIT])
						next_cur.mode_change_irq = 1'b0;
				end
				default:
				begin
					next_cur.irq_en = next_cur.irq_en; // volt handled above
				end
			endcase
		end
		// reads
		if (reg_bus.rd)
		begin
			case (reg_bus.addr)
				LVBC_A_VOLT: next_cur.rdata = {3'h0, cur.output_voltage_code};
				LVBC_A_MODE: next_cur.rdata = {4'h0, cur.standby_state_mode_field,
					cur.run_state_mode_field};
				LVBC_A_CFG: next_cur.rdata = {3'h0, cur.switch_phase_field,
					cur.current_limit_select};
				LVBC_A_STAT: next_cur.rdata = {4'h0, cur.inductor_select_otp,
					cur.state == LVBC_ST_DISCH, cur.mode_change_irq};
				LVBC_A_IEN: next_cur.rdata = {7'h00, cur.irq_en};
				default: next_cur.rdata = 8'h00; // clear reg and unmapped
			endcase
		end
		// mode field follows run or standby state
		sel = lvbc_mode_t'(standby_state ? next_cur.standby_state_mode_field :
			next_cur.run_state_mode_field); // [R14]
		next_cur.prev_mode = sel;
		// set after clear, so a change in the clear cycle survives
		if (cur.state != LVBC_ST_LOAD && sel != cur.prev_mode)
			next_cur.mode_change_irq = 1'b1; // [R08] [R15]
		next_cur.irq_n = !(next_cur.mode_change_irq && next_cur.irq_en); // [R08]
		// drive: voltage is one code for both states, so standby keeps it
		next_cur.drive.mode = sel; // [R07]
		next_cur.drive.enable = sel != LVBC_OFF &&
			next_cur.state == LVBC_ST_RUN; // [R09]
		next_cur.drive.discharge = next_cur.state == LVBC_ST_DISCH; // [R03]
		next_cur.drive.target_mv = volt_mv(next_cur.applied_code); // [R02] [R01]
		next_cur.drive.ilim_ma = ilim_ma(next_cur.current_limit_select); // [R10]
		next_cur.drive.phase_deg = phase_deg(next_cur.switch_phase_field); // [R11]
		next_cur.drive.inductor_nh = ind_nh(next_cur.inductor_select_otp); // [R13]
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// synchronous reset; otp is caught in the load state after it
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cur <= '0;
			cur.state <= LVBC_ST_LOAD;
			cur.switch_phase_field <= LVBC_PHASE_RST; // [R12]
			cur.current_limit_select <= LVBC_ILIM_RST;
			cur.irq_n <= 1'b1;
			cur.prev_mode <= LVBC_OFF;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign rdata = cur.rdata;
	assign drive = cur.drive;
	assign interrupt_out_n = cur.irq_n;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	otp_load_a: assert property (@(posedge sys_clk) disable iff (srst) // [R04]
		cur.state == LVBC_ST_LOAD |=> cur.output_voltage_code == $past(otp.voltage_code)
		&& cur.drive.target_mv == volt_mv($past(otp.voltage_code)))
		else $error("otp voltage not loaded");

	mode_default_a: assert property (@(posedge sys_clk) disable iff (srst) // [R05]
		cur.state == LVBC_ST_LOAD |=> cur.run_state_mode_field ==
		($past(otp.in_sequence) ? 2'h3 : 2'h0) && cur.standby_state_mode_field ==
		cur.run_state_mode_field) // [R06]
		else $error("mode default wrong");

	top_code_a: assert property (@(posedge sys_clk) disable iff (srst) // [R02]
		cur.state == LVBC_ST_RUN && cur.applied_code >= 5'h1B
		|-> cur.drive.target_mv == 13'd4100)
		else $error("top codes not saturated");

	disch_start_a: assert property (@(posedge sys_clk) disable iff (srst) // [R03]
		cur.state == LVBC_ST_RUN && reg_bus.wr && reg_bus.addr == LVBC_A_VOLT
		&& system_on && cur.drive.enable && reg_bus.wdata[4:0] != cur.applied_code
		|=> cur.drive.discharge && !cur.drive.enable
		&& $stable(cur.drive.target_mv))
		else $error("no discharge before retarget");

	disch_end_a: assert property (@(posedge sys_clk) disable iff (srst) // [R03]
		$rose(cur.drive.discharge) |-> cur.drive.discharge[*1] ##[1:DIS_MAX]
		!cur.drive.discharge && cur.applied_code == cur.output_voltage_code)
		else $error("discharge did not end with new code");

	volt_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [R09]
		cur.state == LVBC_ST_RUN && !(reg_bus.wr && reg_bus.addr == LVBC_A_VOLT)
		|=> $stable(cur.drive.target_mv))
		else $error("voltage moved without a write");

	mode_sel_a: assert property (@(posedge sys_clk) disable iff (srst) // [R14]
		cur.state != LVBC_ST_LOAD |=> cur.drive.mode == ($past(standby_state) ?
		cur.standby_state_mode_field : cur.run_state_mode_field)
		&& (cur.drive.enable == (cur.drive.mode != LVBC_OFF && !cur.drive.discharge)))
		else $error("wrong mode field driven"); // [R07]

	irq_set_a: assert property (@(posedge sys_clk) disable iff (srst) // [R08]
		$past(cur.state) != LVBC_ST_LOAD && $changed(cur.drive.mode)
		|-> cur.mode_change_irq && interrupt_out_n == !cur.irq_en)
		else $error("mode change not flagged");

	irq_sticky_a: assert property (@(posedge sys_clk) disable iff (srst) // [R15]
		cur.mode_change_irq && !(reg_bus.wr && reg_bus.addr == LVBC_A_ICLR)
		|=> cur.mode_change_irq)
		else $error("irq flag lost");

	irq_mask_a: assert property (@(posedge sys_clk) disable iff (srst) // [R08]
		!cur.irq_en |-> interrupt_out_n)
		else $error("masked irq drives pin");

	phase_rst_a: assert property (@(posedge sys_clk) // [R12]
		srst ##1 !srst |=> cur.drive.phase_deg == 9'd0)
		else $error("phase not zero at power up");

	cfg_dec_a: assert property (@(posedge sys_clk) disable iff (srst) // [R10]
		cur.state != LVBC_ST_LOAD |-> cur.drive.ilim_ma == ilim_ma(cur.current_limit_select)
		&& cur.drive.phase_deg == phase_deg(cur.switch_phase_field) // [R11]
		&& cur.drive.inductor_nh == ind_nh(cur.inductor_select_otp)) // [R13]
		else $error("config decode wrong");

	disch_c: cover property (@(posedge sys_clk) disable iff (srst)
		$fell(cur.drive.discharge) ##1 cur.drive.enable);
	irq_c: cover property (@(posedge sys_clk) disable iff (srst)
		$fell(interrupt_out_n));
	stby_c: cover property (@(posedge sys_clk) disable iff (srst)
		$rose(standby_state) ##1 cur.drive.enable);
	top_c: cover property (@(posedge sys_clk) disable iff (srst)
		cur.applied_code == 5'h1F);
endmodule

//--- verification/lvbc_host.sv
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module lvbc_host
	import lvbc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] rdata,
	output lvbc_bus_t reg_bus
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idle from time zero, strobes low
	initial reg_bus = '0;

	// one write cycle; released lines show the inverse so stale values never match
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk) reg_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk) reg_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask

	// one read cycle; data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk) reg_bus <= '{addr: a, wdata: ~reg_bus.wdata, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk) reg_bus <= '{addr: ~a, wdata: reg_bus.wdata, wr: 1'b0, rd: 1'b0};
		#1 d = rdata;
	endtask
endmodule

//--- verification/lvbc_top_tb.sv
// ----------------------------------------
// compare helper
// ----------------------------------------
`define CHK(a, b) if ((a) !== (b)) begin $display("[ERR] t=%0t got %h exp %h", \
	$time, a, b); bad_count++; end n_checks++;

module lvbc_top_tb
	import lvbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// short discharge keeps the run brief; checks scale from it
	localparam int NDIS = 6;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	lvbc_bus_t reg_bus;
	logic [7:0] rdata;
	lvbc_otp_t otp = '0;
	logic system_on = 1'b1;
	logic standby_state = 1'b0;
	lvbc_drive_t drive;
	logic interrupt_out_n;
	logic [7:0] d; // last read data
	int bad_count = 0;
	int n_checks = 0;
	// target millivolts per voltage code
	int vt[32] = '{1000, 1100, 1200, 1250, 1300, 1350, 1500, 1600, 1800, 1850, 2000,
		2100, 2150, 2250, 2300, 2400, 2500, 2800, 3150, 3200, 3250, 3300, 3350, 3400,
		3500, 3800, 4000, 4100, 4100, 4100, 4100, 4100};
	int lt[4] = '{1000, 470, 1500, 0}; // inductor nH, reserved reads 0
	int it[4] = '{2100, 2600, 3000, 4500}; // peak limit mA

	// ----------------------------------------
	// clock, design and host
	// ----------------------------------------
	always #50 sys_clk = ~sys_clk;

	lvbc_top #(.DISCHARGE_CYCLES(NDIS)) dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.reg_bus(reg_bus),
		.rdata(rdata),
		.otp(otp),
		.system_on(system_on),
		.standby_state(standby_state),
		.drive(drive),
		.interrupt_out_n(interrupt_out_n)
	);

	lvbc_host host (
		.sys_clk(sys_clk),
		.rdata(rdata),
		.reg_bus(reg_bus)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// wait n edges, then let their updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// reset with a fresh otp image; otp is sampled right after release
	task automatic do_reset(input logic [4:0] v, input logic s, input logic [1:0] l);
		@(posedge sys_clk) srst <= 1'b1;
		otp <= '{voltage_code: v, in_sequence: s, inductor_select: l};
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		cyc(3);
	endtask

	// verdict and end of run
	task automatic conclude();
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles of the tests
	initial
	begin
		#5ms;
		bad_count++;
		conclude();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		// power-up defaults for each inductor code, sequenced or not
		for (int i = 0; i < 4; i++)
		begin
			do_reset(5'(i * 9), i[0], 2'(i));
			`CHK(drive.target_mv, 13'(vt[i * 9]))
			`CHK(drive.mode, {2{i[0]}})
			`CHK(drive.enable, i[0])
			host.rd(LVBC_A_MODE, d);
			`CHK(d, {4'h0, {4{i[0]}}})
			`CHK(drive.inductor_nh, 11'(lt[i]))
			`CHK(drive.phase_deg, 9'h000)
			`CHK(drive.ilim_ma, 13'(it[0]))
			host.rd(LVBC_A_STAT, d);
			`CHK(d, {4'h0, 2'(i), 2'b00})
		end
		// every voltage code while off: applied directly, no discharge
		@(posedge sys_clk) system_on <= 1'b0;
		for (int c = 0; c < 32; c++)
		begin
			host.wr(LVBC_A_VOLT, 8'(c));
			cyc(2);
			`CHK(drive.target_mv, 13'(vt[c]))
			`CHK(drive.discharge, 1'b0)
		end
		host.rd(LVBC_A_VOLT, d);
		`CHK(d, 8'h1F)
		@(posedge sys_clk) system_on <= 1'b1;
		// every phase code, each beside limit code p mod 4
		for (int p = 0; p < 8; p++)
		begin
			host.wr(LVBC_A_CFG, 8'({3'(p), 2'(p)}));
			cyc(2);
			`CHK(drive.phase_deg, 9'(((p + 1) % 8) * 45))
			`CHK(drive.ilim_ma, 13'(it[p % 4]))
		end
		// each run mode raises the flag; masked, the pin stays high
		host.wr(LVBC_A_IEN, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			host.wr(LVBC_A_ICLR, 8'h01);
			host.wr(LVBC_A_MODE, 8'(m));
			cyc(3);
			`CHK(drive.mode, 2'(m))
			`CHK(drive.enable, m != 0)
			host.rd(LVBC_A_STAT, d);
			`CHK(d[0], 1'b1)
			`CHK(interrupt_out_n, 1'b1)
		end
		host.wr(LVBC_A_ICLR, 8'h01);
		host.wr(LVBC_A_IEN, 8'h01);
		host.rd(LVBC_A_STAT, d);
		`CHK(d[0], 1'b0)
		// rewriting the same mode is no change, so no interrupt
		host.wr(LVBC_A_MODE, 8'h03);
		cyc(3);
		`CHK(interrupt_out_n, 1'b1)
		host.wr(LVBC_A_MODE, 8'h09); // standby pfm, run pwm
		cyc(3);
		`CHK(interrupt_out_n, 1'b0)
		host.wr(LVBC_A_ICLR, 8'h01);
		cyc(2);
		`CHK(interrupt_out_n, 1'b1)
		// run to standby swaps the field, keeps the voltage
		@(posedge sys_clk) standby_state <= 1'b1;
		cyc(3);
		`CHK(drive.mode, LVBC_PFM)
		`CHK(drive.target_mv, 13'(vt[31]))
		`CHK(interrupt_out_n, 1'b0)
		host.wr(LVBC_A_MODE, 8'h01); // standby off
		cyc(3);
		`CHK(drive.enable, 1'b0)
		@(posedge sys_clk) standby_state <= 1'b0;
		cyc(3);
		`CHK(drive.mode, LVBC_PWM)
		`CHK(drive.enable, 1'b1)
		// code change while on: discharge, late write wins at restart
		host.wr(LVBC_A_VOLT, 8'h08);
		host.rd(LVBC_A_STAT, d);
		`CHK(d[1], 1'b1)
		`CHK({drive.discharge, drive.enable}, 2'b10)
		`CHK(drive.target_mv, 13'(vt[31]))
		host.wr(LVBC_A_VOLT, 8'h05);
		cyc(0);
		`CHK(drive.discharge, 1'b1)
		cyc(NDIS + 2);
		`CHK({drive.discharge, drive.enable}, 2'b01)
		`CHK(drive.target_mv, 13'(vt[5]))
		host.wr(LVBC_A_VOLT, 8'h05);
		cyc(1);
		`CHK(drive.discharge, 1'b0)
		// clear register and unmapped index read zero
		host.rd(LVBC_A_ICLR, d);
		`CHK(d, 8'h00)
		host.rd(4'hF, d);
		`CHK(d, 8'h00)
		conclude();
	end
endmodule
